// ===== include/bmr_pkg.sv
// package: register map, fields, commands and carriers of the monitor
package bmr_pkg;
   // ****************************************
   // link and memory geometry
   // ****************************************
   localparam int ADDR_W = 7;
   localparam int CMD_WR_BIT = 7;
   localparam int RAM_BYTES = 32;
   localparam int FLASH_BYTES = 96;
   localparam int PAGE_BYTES = 32;
   localparam int NCNT = 5;
   localparam int SLOW_DIV = 256;
   localparam logic [6:0] A_RAM_HI = 7'h1F;
   localparam logic [6:0] A_FLASH_HI = 7'h5F;
   localparam logic [6:0] A_TEMPERATURE_LOW = 7'h60;
   localparam logic [6:0] A_TEMPERATURE_HIGH = 7'h61;
   localparam logic [6:0] A_FLASH_CONTROL_COMMAND = 7'h62;
   localparam logic [6:0] A_CLR = 7'h63;
   localparam logic [6:0] A_MODE = 7'h64;
   localparam logic [6:0] A_CHARGE_TIME_LOW = 7'h65;
   localparam logic [6:0] A_CHARGE_TIME_HIGH = 7'h66;
   localparam logic [6:0] A_DISCHARGE_TIME_LOW = 7'h67;
   localparam logic [6:0] A_DISCHARGE_TIME_HIGH = 7'h68;
   localparam logic [6:0] A_SELF_DISCHARGE_LOW = 7'h69;
   localparam logic [6:0] A_SELF_DISCHARGE_HIGH = 7'h6A;
   localparam logic [6:0] A_CHARGE_COUNT_LOW = 7'h6B;
   localparam logic [6:0] A_CHARGE_COUNT_HIGH = 7'h6C;
   localparam logic [6:0] A_DISCHARGE_COUNT_LOW = 7'h6D;
   localparam logic [6:0] A_DISCHARGE_COUNT_HIGH = 7'h6E;
   localparam logic [6:0] A_FPD = 7'h6F;
   localparam logic [6:0] A_FPA = 7'h70;
   localparam logic [6:0] A_VRL = 7'h71;
   localparam logic [6:0] A_VRH = 7'h72;
   localparam logic [6:0] A_RSV_LO = 7'h73;
   localparam logic [6:0] A_RSV_HI = 7'h77;
   localparam logic [6:0] A_ID_LO = 7'h78;
   localparam logic [6:0] A_GAIN = 7'h79;
   // ****************************************
   // register fields and reset values
   // ****************************************
   localparam int M_GENERAL_PIN_ENABLE = 7;
   localparam int M_STAT = 6;
   localparam int M_STC = 5;
   localparam int M_STD = 4;
   localparam int M_WOE = 1;
   localparam int M_POR = 0;
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [7:0] MODE_HOST = 8'hCF;
   localparam int C_DCR = 0;
   localparam int C_CCR = 1;
   localparam int C_SCR = 2;
   localparam int C_DTC = 3;
   localparam int C_CTC = 4;
   localparam logic [7:0] CLR_MASK = 8'h1F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ERASED = 8'hFF;
   localparam logic [2:0] ID_GAIN = 3'h1;
   localparam logic [2:0] ID_ZERO = 3'h6;
   localparam logic [2:0] ID_DEV = 3'h7;
   // ****************************************
   // flash and control commands
   // ****************************************
   localparam logic [7:0] FC_PROG = 8'h0F;
   localparam logic [7:0] FC_ERASE0 = 8'h40;
   localparam logic [7:0] FC_R2F = 8'h45;
   localparam logic [7:0] FC_F2R = 8'h48;
   localparam logic [7:0] FC_PDN = 8'hF6;
   // ****************************************
   // result scaling, host side arithmetic
   // ****************************************
   localparam int VOLT_LSB_UV = 2440;
   localparam int OFS_STEP_MV = 8;
   localparam int FULL_SCALE_MV = 5000;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic sign;
      logic [3:0] mag;
      logic [10:0] code;
   } bmr_volt_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } bmr_byte_t;
   typedef enum logic [1:0] {
      LS_CMD = 2'b01,
      LS_DATA = 2'b10
   } bmr_link_t;
endpackage

// ===== logic/bmr_identity_rom.sv
// identity rom with gain correction byte
module bmr_identity_rom import bmr_pkg::*; #(
   parameter logic [7:0] DEV_CODE = 8'h5A,
   parameter logic [7:0] GAIN_CORR = 8'h00,
   parameter logic [7:0] FILL = 8'hA5
) (
   input logic [2:0] idx,
   output logic [7:0] data
);
   // device code value is arbitrary
   wire is_dev = idx == ID_DEV;
   wire is_zero = idx == ID_ZERO;
   wire is_gain = idx == ID_GAIN;
   // gain correction in two's complement microvolts per code step
   assign data = is_dev ? DEV_CODE : is_zero ? BYTE_ZERO :
                 is_gain ? GAIN_CORR : (FILL ^ {5'h00, idx});
endmodule // bmr_identity_rom

// ===== logic/bmr_counter.sv
// 16-bit event counter with clear and slow-rate prescaler
module bmr_counter import bmr_pkg::*; #(
   parameter int DIV = SLOW_DIV
) (
   input logic clk,
   input logic rst,
   input logic clr,
   input logic inc,
   input logic slow,
   output logic [15:0] count,
   output logic roll
);
   logic [15:0] count_q, count_d;
   logic [7:0] pre_q, pre_d;
   // ****************************************
   // prescaler and count
   // ****************************************
   wire pre_end = pre_q == 8'(DIV - 1);
   wire tick = inc & (~slow | pre_end);
   assign roll = tick & ~clr & (&count_q);
   assign count_d = clr ? 16'h0000 : tick ? count_q + 16'h0001 : count_q;
   assign pre_d = (clr | ~slow) ? 8'h00 :
                  inc ? (pre_end ? 8'h00 : pre_q + 8'h01) : pre_q;
   assign count = count_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= 16'h0000;
         pre_q <= 8'h00;
      end else begin
         count_q <= count_d;
         pre_q <= pre_d;
      end
   end
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_cnt_clear: assert property (clr |=> count_q == 16'h0000)
      else $error("counter not zero after clear");
   chk_slow_hold: assert property (
      slow && inc && !clr && !pre_end |=> $stable(count_q))
      else $error("slow counter advanced before prescale end");
endmodule // bmr_counter

// ===== logic/bmr_top.sv
// register map of the battery monitor behind the byte command link
// Functional notes
// - battery voltage result exposed as register pair
// - 11-bit result at 0x72[2:0] and 0x71
// - msb in high bit 2, lsb low bit 0
// - full scale code stands for 5 V
// - high bits 7..3 hold sign-magnitude offset
// - identity byte 0x79 holds gain correction
// - 128 locations: rom, ram, flash, sfr
// - command byte: bit7 write, bits6..0 address
// - clear bit zeroes counter, then self-clears
// - time counter rollover sets slow-rate mode bit
module bmr_top import bmr_pkg::*; #(
   parameter logic [7:0] DEV_CODE = 8'h5A,
   parameter logic [7:0] GAIN_CORR = 8'h00
) (
   input logic clk,
   input logic rst,
   input bmr_byte_t rx,
   input logic link_break,
   output bmr_byte_t tx,
   input logic adc_valid,
   input bmr_volt_t adc_volt,
   input logic temp_valid,
   input logic [10:0] temp_value,
   input logic chg_pulse,
   input logic dis_pulse,
   input logic self_pulse,
   input logic chg_tick,
   input logic dis_tick,
   output logic general_pin_enable,
   output logic [2:0] wake_threshold_select,
   output logic power_down_req
);
   // ****************************************
   // state
   // ****************************************
   bmr_link_t state_q, state_d;
   logic [6:0] addr_q;
   bmr_byte_t tx_q;
   bmr_volt_t volt_q;
   logic [10:0] temp_q;
   logic [7:0] mode_q, mode_d;
   logic [7:0] clr_q, clr_d;
   logic [7:0] flash_control_command_q, fpd_q, fpa_q;
   logic flash_control_command_go_q, pdn_q;
   logic [7:0] ram_q [RAM_BYTES];
   logic [7:0] ram_d [RAM_BYTES];
   // nonvolatile: powers up erased and survives reset
   logic [7:0] flash_q [FLASH_BYTES] = '{default: BYTE_ERASED};
   logic [7:0] flash_d [FLASH_BYTES];
   logic [15:0] cnt [NCNT];
   logic [NCNT-1:0] roll, cnt_inc, cnt_slow;
   logic [7:0] id_byte, sfr_byte;

   // ****************************************
   // command link
   // ****************************************
   wire rx_go = rx.valid & ~link_break;
   wire in_cmd = state_q == LS_CMD;
   wire is_wr_cmd = rx.data[CMD_WR_BIT];
   wire rd_take = in_cmd & rx_go & ~is_wr_cmd;
   wire wr_take = in_cmd & rx_go & is_wr_cmd;
   wire wr_en = (state_q == LS_DATA) & rx_go;
   wire [6:0] rd_addr = rx.data[ADDR_W-1:0];
   wire [7:0] wdata = rx.data;

   always_comb begin
      state_d = state_q;
      case (state_q)
         LS_CMD: begin
            if (wr_take) begin
               state_d = LS_DATA;
            end
         end
         LS_DATA: begin
            if (rx_go) begin
               state_d = LS_CMD;
            end
         end
         default: begin
            state_d = LS_CMD;
         end
      endcase
      if (link_break) begin
         state_d = LS_CMD;
      end
   end

   // ****************************************
   // read selection
   // ****************************************
   wire rd_in_ram = rd_addr <= A_RAM_HI;
   wire rd_in_flash = ~rd_in_ram & (rd_addr <= A_FLASH_HI);
   wire rd_in_id = rd_addr >= A_ID_LO;
   wire [2:0] id_idx = 3'(rd_addr - A_ID_LO);
   wire [7:0] rd_byte = rd_in_ram ? ram_q[rd_addr[4:0]] :
                        rd_in_flash ? flash_q[rd_addr] :
                        rd_in_id ? id_byte : sfr_byte;

   bmr_identity_rom #(
      .DEV_CODE(DEV_CODE),
      .GAIN_CORR(GAIN_CORR),
      .FILL(8'hA5)
   ) u_identity_rom (
      .idx(id_idx),
      .data(id_byte)
   );

   always_comb begin
      case (rd_addr)
         A_TEMPERATURE_LOW: sfr_byte = temp_q[7:0];
         A_TEMPERATURE_HIGH: sfr_byte = {5'h00, temp_q[10:8]};
         A_FLASH_CONTROL_COMMAND: sfr_byte = flash_control_command_q;
         A_CLR: sfr_byte = clr_q;
         A_MODE: sfr_byte = mode_q;
         A_CHARGE_TIME_LOW: sfr_byte = cnt[C_CTC][7:0];
         A_CHARGE_TIME_HIGH: sfr_byte = cnt[C_CTC][15:8];
         A_DISCHARGE_TIME_LOW: sfr_byte = cnt[C_DTC][7:0];
         A_DISCHARGE_TIME_HIGH: sfr_byte = cnt[C_DTC][15:8];
         A_SELF_DISCHARGE_LOW: sfr_byte = cnt[C_SCR][7:0];
         A_SELF_DISCHARGE_HIGH: sfr_byte = cnt[C_SCR][15:8];
         A_CHARGE_COUNT_LOW: sfr_byte = cnt[C_CCR][7:0];
         A_CHARGE_COUNT_HIGH: sfr_byte = cnt[C_CCR][15:8];
         A_DISCHARGE_COUNT_LOW: sfr_byte = cnt[C_DCR][7:0];
         A_DISCHARGE_COUNT_HIGH: sfr_byte = cnt[C_DCR][15:8];
         A_FPD: sfr_byte = fpd_q;
         A_FPA: sfr_byte = fpa_q;
         A_VRL: sfr_byte = volt_q[7:0];
         A_VRH: sfr_byte = volt_q[15:8];
         default: sfr_byte = BYTE_ZERO;
      endcase
   end

   // ****************************************
   // write decode
   // ****************************************
   wire wr_ram = wr_en & (addr_q <= A_RAM_HI);
   wire wr_flash_control_command = wr_en & (addr_q == A_FLASH_CONTROL_COMMAND);
   wire wr_clr = wr_en & (addr_q == A_CLR);
   wire wr_mode = wr_en & (addr_q == A_MODE);
   wire wr_fpd = wr_en & (addr_q == A_FPD);
   wire wr_fpa = wr_en & (addr_q == A_FPA);

   // ****************************************
   // counters and mode
   // ****************************************
   assign cnt_inc = {chg_tick, dis_tick, self_pulse, chg_pulse, dis_pulse};
   assign cnt_slow = {mode_q[M_STC], mode_q[M_STD], 3'b000};

   genvar g;
   generate
      for (g = 0; g < NCNT; g++) begin : g_cnt
         bmr_counter #(
            .DIV(SLOW_DIV)
         ) u_cnt (
            .clk(clk),
            .rst(rst),
            .clr(clr_q[g]),
            .inc(cnt_inc[g]),
            .slow(cnt_slow[g]),
            .count(cnt[g]),
            .roll(roll[g])
         );
      end
   endgenerate

   // one cycle of clearing completes the request; a new write wins
   assign clr_d = wr_clr ? (wdata & CLR_MASK) : BYTE_ZERO;

   wire stc_d = roll[C_CTC] | (mode_q[M_STC] & ~clr_q[C_CTC]);
   wire std_d = roll[C_DTC] | (mode_q[M_STD] & ~clr_q[C_DTC]);
   wire [7:0] mode_host = wr_mode ? (wdata & MODE_HOST) : (mode_q & MODE_HOST);
   always_comb begin
      mode_d = mode_host;
      mode_d[M_STC] = stc_d;
      mode_d[M_STD] = std_d;
   end

   // ****************************************
   // shadow ram and flash
   // ****************************************
   wire fc_prog = flash_control_command_go_q & (flash_control_command_q == FC_PROG);
   wire fc_r2f = flash_control_command_go_q & (flash_control_command_q == FC_R2F);
   wire fc_f2r = flash_control_command_go_q & (flash_control_command_q == FC_F2R);
   wire fc_pdn = flash_control_command_go_q & (flash_control_command_q == FC_PDN);

   generate
      for (g = 0; g < FLASH_BYTES; g++) begin : g_fl
         localparam logic [7:0] IDX = 8'(g);
         localparam logic [7:0] ERASE = FC_ERASE0 + 8'(g / PAGE_BYTES);
         wire erase = flash_control_command_go_q & (flash_control_command_q == ERASE);
         wire prog = fc_prog & (fpa_q == IDX);
         wire shadow = fc_r2f & (g < RAM_BYTES);
         assign flash_d[g] = erase ? BYTE_ERASED :
                             prog ? (flash_q[g] & fpd_q) :
                             shadow ? (flash_q[g] & ram_q[g % RAM_BYTES]) :
                             flash_q[g];
      end
      for (g = 0; g < RAM_BYTES; g++) begin : g_ram
         wire host = wr_ram & (addr_q[4:0] == 5'(g));
         assign ram_d[g] = host ? wdata : fc_f2r ? flash_q[g] : ram_q[g];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst) begin
         flash_q <= flash_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < RAM_BYTES; i++) begin
            ram_q[i] <= flash_q[i];
         end
      end else begin
         ram_q <= ram_d;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= LS_CMD;
         addr_q <= 7'h00;
         tx_q <= '0;
      end else begin
         state_q <= state_d;
         if (wr_take) begin
            addr_q <= rd_addr;
         end
         tx_q.valid <= rd_take;
         tx_q.data <= rd_take ? rd_byte : tx_q.data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         volt_q <= '0;
         temp_q <= 11'h000;
      end else begin
         if (adc_valid) begin
            volt_q <= adc_volt;
         end
         if (temp_valid) begin
            temp_q <= temp_value;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= MODE_RST;
         clr_q <= BYTE_ZERO;
         flash_control_command_q <= BYTE_ZERO;
         fpd_q <= BYTE_ZERO;
         fpa_q <= BYTE_ZERO;
         flash_control_command_go_q <= 1'b0;
         pdn_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         clr_q <= clr_d;
         flash_control_command_go_q <= wr_flash_control_command;
         pdn_q <= fc_pdn;
         if (wr_flash_control_command) begin
            flash_control_command_q <= wdata;
         end
         if (wr_fpd) begin
            fpd_q <= wdata;
         end
         if (wr_fpa) begin
            fpa_q <= wdata;
         end
      end
   end

   assign tx = tx_q;
   assign general_pin_enable = mode_q[M_GENERAL_PIN_ENABLE];
   assign wake_threshold_select = mode_q[M_WOE +: 3];
   assign power_down_req = pdn_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_read_answer: assert property (
      rd_take |=> tx_q.valid ##1 !tx_q.valid || $past(rd_take))
      else $error("read command not answered in one cycle");
   chk_write_cmd: assert property (
      wr_take ##1 rx_go |=> $past(wr_en) && state_q == LS_CMD)
      else $error("write command did not take its data byte");
   chk_volt_high: assert property (
      rd_take && rd_addr == A_VRH |=> tx_q.data == $past(volt_q[15:8]))
      else $error("voltage high byte mismatch");
   chk_volt_low: assert property (
      rd_take && rd_addr == A_VRL |=> tx_q.data == $past(volt_q[7:0]))
      else $error("voltage low byte mismatch");
   chk_rsvd_zero: assert property (
      rd_take && rd_addr >= A_RSV_LO && rd_addr <= A_RSV_HI
      |=> tx_q.data == BYTE_ZERO)
      else $error("reserved location read nonzero");
   chk_gain_rom: assert property (
      rd_take && rd_addr == A_GAIN |=> tx_q.data == GAIN_CORR)
      else $error("gain correction byte mismatch");
   chk_clear_auto: assert property (
      wr_clr && (wdata & CLR_MASK) != BYTE_ZERO ##1 !wr_clr
      |=> clr_q == BYTE_ZERO)
      else $error("clear bit did not return to zero");
   chk_slow_set: assert property (
      roll[C_CTC] |=> mode_q[M_STC] && cnt[C_CTC] == 16'h0000)
      else $error("rollover did not set slow mode");
   chk_slow_reset: assert property (
      clr_q[C_DTC] |=> !mode_q[M_STD] && cnt[C_DTC] == 16'h0000)
      else $error("clear did not drop slow mode");
   chk_tx_width: assert property (
      rd_take && rd_addr == A_TEMPERATURE_HIGH |=> tx_q.data[7:3] == 5'h00)
      else $error("reserved temperature bits nonzero");

   cov_read: cover property (rd_take ##1 tx_q.valid);
   cov_write_ram: cover property (wr_ram);
   cov_prog: cover property (fc_prog);
   cov_roll: cover property (roll[C_CTC]);
endmodule // bmr_top

// ===== sim/bmr_host_model.sv
// host side model of the byte command link
module bmr_host_model import bmr_pkg::*; (
   input wire logic clk,
   output bmr_byte_t rx,
   input wire bmr_byte_t tx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx = '{valid: 1'b0, data: 8'h00};
   end
   // write: command byte then data byte, back to back
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      rx = '{valid: 1'b1, data: {1'b1, a}};
      @(negedge clk);
      rx = '{valid: 1'b1, data: d};
      @(negedge clk);
      rx = '{valid: 1'b0, data: ~d};
      @(negedge clk);
   endtask
   // read: command byte alone, answer one cycle later
   task automatic rd(input logic [6:0] a, output logic [7:0] d,
                     output logic v);
      rx = '{valid: 1'b1, data: {1'b0, a}};
      @(negedge clk);
      v = tx.valid;
      d = tx.data;
      rx = '{valid: 1'b0, data: {1'b1, ~a}};
      @(negedge clk);
   endtask
   // corrected voltage in microvolts, applied by the host only
   function automatic int volt_uv(input bmr_volt_t r, input logic [7:0] g);
      volt_uv = int'(r.code) * (VOLT_LSB_UV + int'(signed'(g))) -
                (r.sign ? -1 : 1) * int'(r.mag) * OFS_STEP_MV * 1000;
   endfunction
endmodule // bmr_host_model

// ===== sim/tb.sv
// self-checking testbench of the monitor register map
`define CHK(a, b) begin \
   checks++; \
   if ((a) !== (b)) begin \
      $display("[FAIL] t=%0t got %h exp %h", $time, a, b); \
      err_total++; \
   end \
end
module tb import bmr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals and instances
   // ****************************************
   logic clk, rst, link_break, adc_valid, temp_valid;
   logic chg_pulse, dis_pulse, self_pulse, chg_tick, dis_tick, gpe, pdr;
   logic [2:0] wts;
   logic [10:0] temp_value;
   bmr_volt_t adc_volt;
   bmr_byte_t rx, tx;
   int err_total, checks, cyc;
   bmr_top #(.DEV_CODE(8'h3C), .GAIN_CORR(8'hF6)) i_bmr_top (
      .clk(clk), .rst(rst), .rx(rx), .link_break(link_break), .tx(tx),
      .adc_valid(adc_valid), .adc_volt(adc_volt), .temp_valid(temp_valid),
      .temp_value(temp_value), .chg_pulse(chg_pulse),
      .dis_pulse(dis_pulse), .self_pulse(self_pulse), .chg_tick(chg_tick),
      .dis_tick(dis_tick), .general_pin_enable(gpe),
      .wake_threshold_select(wts), .power_down_req(pdr));
   bmr_host_model i_bmr_host_model (.clk(clk), .rx(rx), .tx(tx));
   // ****************************************
   // clock, reset, timeout
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      if (err_total == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ****************************************
   // helpers
   // ****************************************
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      i_bmr_host_model.rd(a, d, v);
      `CHK(v, 1'b1)
      `CHK(d, e)
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_bmr_host_model.wr(a, d);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk(A_MODE, MODE_RST);
      rd_chk(A_CLR, 8'h00);
      rd_chk(A_VRH, 8'h00);
      rd_chk(7'h05, BYTE_ERASED);
      `CHK(gpe, 1'b0)
      `CHK(wts, 3'h0)
   endtask
   task automatic t_volt(input bmr_volt_t v, input logic [7:0] eh,
                         input logic [7:0] el);
      adc_volt = v;
      adc_valid = 1'b1;
      idle(1);
      adc_valid = 1'b0;
      adc_volt = ~v;
      rd_chk(A_VRH, eh);
      rd_chk(A_VRL, el);
   endtask
   task automatic t_temp();
      temp_value = 11'h5C3;
      temp_valid = 1'b1;
      idle(1);
      temp_valid = 1'b0;
      rd_chk(A_TEMPERATURE_LOW, 8'hC3);
      rd_chk(A_TEMPERATURE_HIGH, 8'h05);
   endtask
   task automatic t_identity_rom();
      rd_chk(A_GAIN, 8'hF6);
      `CHK(i_bmr_host_model.volt_uv('{sign: 1'b0, mag: 4'hA, code: 11'h5A5}, 8'hF6), 3431350)
      rd_chk(7'h7F, 8'h3C);
      rd_chk(7'h7E, 8'h00);
      wr(A_GAIN, 8'h00);
      rd_chk(A_GAIN, 8'hF6);
   endtask
   task automatic t_rsvd();
      for (int a = 'h73; a <= 'h77; a++) begin
         wr(7'(a), 8'hFF);
         rd_chk(7'(a), 8'h00);
      end
   endtask
   task automatic t_ram();
      wr(7'h1F, 8'hA5);
      rd_chk(7'h1F, 8'hA5);
      wr(A_FPA, 8'h33);
      rd_chk(A_FPA, 8'h33);
      link_break = 1'b1;
      wr(A_FPA, 8'h77);
      link_break = 1'b0;
      rd_chk(A_FPA, 8'h33);
      wr(7'h05, 8'h5A);
      wr(A_FLASH_CONTROL_COMMAND, FC_F2R);
      idle(3);
      rd_chk(7'h05, BYTE_ERASED);
      wr(7'h05, 8'h5A);
      wr(A_FLASH_CONTROL_COMMAND, FC_R2F);
      wr(7'h05, 8'h00);
      wr(A_FLASH_CONTROL_COMMAND, FC_F2R);
      idle(2);
      rd_chk(7'h05, 8'h5A);
   endtask
   task automatic t_clear();
      chg_pulse = 1'b1;
      self_pulse = 1'b1;
      dis_tick = 1'b1;
      idle(3);
      chg_pulse = 1'b0;
      self_pulse = 1'b0;
      dis_tick = 1'b0;
      dis_pulse = 1'b1;
      idle(2);
      dis_pulse = 1'b0;
      rd_chk(A_CHARGE_COUNT_LOW, 8'h03);
      rd_chk(A_DISCHARGE_COUNT_LOW, 8'h02);
      rd_chk(A_SELF_DISCHARGE_LOW, 8'h03);
      rd_chk(A_DISCHARGE_TIME_LOW, 8'h03);
      wr(A_CLR, 8'h01 << C_CCR);
      idle(4);
      rd_chk(A_CLR, 8'h00);
      rd_chk(A_CHARGE_COUNT_LOW, 8'h00);
      rd_chk(A_DISCHARGE_COUNT_LOW, 8'h02);
      rd_chk(A_SELF_DISCHARGE_LOW, 8'h03);
   endtask
   task automatic t_roll();
      chg_tick = 1'b1;
      idle(65536);
      chg_tick = 1'b0;
      rd_chk(A_MODE, MODE_RST | (8'h01 << M_STC));
      rd_chk(A_CHARGE_TIME_HIGH, 8'h00);
      chg_tick = 1'b1;
      idle(255);
      chg_tick = 1'b0;
      rd_chk(A_CHARGE_TIME_LOW, 8'h00);
      chg_tick = 1'b1;
      idle(1);
      chg_tick = 1'b0;
      rd_chk(A_CHARGE_TIME_LOW, 8'h01);
      wr(A_CLR, (8'h01 << C_CTC) | (8'h01 << C_DTC));
      idle(4);
      rd_chk(A_MODE, MODE_RST);
      rd_chk(A_DISCHARGE_TIME_LOW, 8'h00);
   endtask
   task automatic t_mode();
      wr(A_MODE, 8'hFF);
      idle(2);
      rd_chk(A_MODE, MODE_HOST);
      `CHK(gpe, 1'b1)
      `CHK(wts, 3'h7)
   endtask
   task automatic t_pdn();
      int n;
      n = 0;
      wr(A_FLASH_CONTROL_COMMAND, FC_PDN);
      repeat (6) begin
         if (pdr === 1'b1) n++;
         @(negedge clk);
      end
      `CHK(n, 1)
      rd_chk(A_FLASH_CONTROL_COMMAND, FC_PDN);
   endtask
   task automatic t_flash();
      wr(A_FPA, 8'h20);
      wr(A_FPD, 8'h3C);
      wr(A_FLASH_CONTROL_COMMAND, FC_PROG);
      idle(3);
      rd_chk(7'h20, 8'h3C);
      rd_chk(7'h21, BYTE_ERASED);
      wr(A_FLASH_CONTROL_COMMAND, 8'h41);
      idle(3);
      rd_chk(7'h20, BYTE_ERASED);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      err_total = 0;
      checks = 0;
      cyc = 0;
      rst = 1'b1;
      {link_break, adc_valid, temp_valid, chg_pulse, dis_pulse} = '0;
      {self_pulse, chg_tick, dis_tick} = '0;
      temp_value = '0;
      adc_volt = '0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_volt('{sign: 1'b0, mag: 4'hA, code: 11'h5A5}, 8'h55, 8'hA5);
      t_volt('{sign: 1'b1, mag: 4'hA, code: 11'h7FF}, 8'hD7, 8'hFF);
      t_temp();
      t_identity_rom();
      t_rsvd();
      t_ram();
      t_clear();
      t_roll();
      t_mode();
      t_pdn();
      t_flash();
      results();
   end
endmodule // tb
